// ===== dv/lin_master_model.sv
`timescale 1ns/100ps
`default_nettype none
// bus master: break, delimiter and framed bytes onto the slave rx pin
module lin_master_model #(
	parameter int BIT_CYC = 20
) (
	input  wire logic clock_in,
	output var logic  lin_out
);
	// idle bus sits at its pull-up level
	initial lin_out = 1'b1;
	// level for n bit times at the fixed rate
	task automatic hold(input logic v, input int n);
		lin_out = v;
		repeat (n * BIT_CYC) @(negedge clock_in);
	endtask
	// one 8n1 byte, least significant bit first
	task automatic put(input logic [7:0] b);
		hold(1'b0, 1);
		for (int i = 0; i < 8; i++) begin
			hold(b[i], 1);
		end
		hold(1'b1, 1);
	endtask
	// protected id, data, then classic or enhanced sum
	task automatic send(input logic [5:0] id, input logic [15:0] d, input logic enh);
		logic [7:0] pid;
		logic [8:0] s;
		pid = {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4], id};
		s = enh ? {1'b0, pid} : 9'h000;
		for (int i = 0; i < 2; i++) begin
			s = s + {1'b0, d[8*i+:8]};
			if (s[8]) s = s - 9'h0FF;
		end
		hold(1'b0, 13);
		hold(1'b1, 1);
		put(8'h55);
		put(pid);
		put(d[7:0]);
		put(d[15:8]);
		put(~s[7:0]);
	endtask
endmodule
`default_nettype wire

// ===== dv/window_lift_motor_control_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module window_lift_motor_control_assertions #(
	parameter int BIT_CYC   = 10416,
	parameter int IDLE_BITS = 25000
) (
	input  wire logic        clock_in,
	input  wire logic        arst_n_in,
	input  wire logic        lin_rx_in,
	input  wire logic        cmd_open_in,
	input  wire logic        cmd_close_in,
	input  wire logic        cmd_goto_in,
	input  wire logic        left_node_select_in,
	input  wire logic        right_node_select_in,
	input  wire logic        motor_on_out,
	input  wire logic [15:0] position_out,
	input  wire logic [14:0] position_mm_out,
	input  wire logic        obstruction_out,
	input  wire logic        sensor_missing_out,
	input  wire logic        sleep_out,
	input  wire logic        frame_valid_out,
	input  wire logic [5:0]  frame_id_out
);
	import window_lift_pkg::*;
	localparam int QUIET = IDLE_BITS * BIT_CYC - 8;
	logic        any_start;
	logic [31:0] quiet_q;
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!arst_n_in);
	// any command that clears sticky flags
	assign any_start = cmd_open_in | cmd_close_in | cmd_goto_in;
	// cycles since the bus pin last moved
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) quiet_q <= '0;
		else if ($changed(lin_rx_in)) quiet_q <= '0;
		else quiet_q <= quiet_q + 32'h1;
	end
	a_mm_half: assert property (
		$stable(position_out) |-> position_mm_out == position_out[15:1])
		else $error("millimetre count is not half the position");
	a_pos_step: assert property (
		position_out != $past(position_out) |->
		(position_out - $past(position_out)) inside {16'h0001, 16'hFFFF})
		else $error("position moved by more than one");
	a_start_drive: assert property (
		(cmd_open_in || cmd_close_in) |-> ##2 motor_on_out)
		else $error("motor not driven two cycles after start");
	a_obstr_halt: assert property (
		$rose(obstruction_out) |-> ##[0:2] !motor_on_out)
		else $error("motor still on after obstruction");
	a_obstr_hold: assert property (
		$fell(obstruction_out) |-> $past(any_start, 1) || $past(any_start, 2))
		else $error("obstruction flag dropped without a start");
	a_missing_halt: assert property (
		$rose(sensor_missing_out) |-> ##[0:2] !motor_on_out)
		else $error("motor still on after sensor loss");
	a_frame_node: assert property (
		frame_valid_out |-> left_node_select_in != right_node_select_in &&
		frame_id_out == (left_node_select_in ? LEFT_FRAME_ID : RIGHT_FRAME_ID))
		else $error("frame accepted for wrong node");
	a_wake_edge: assert property (
		$changed(lin_rx_in) |-> ##[1:8] !sleep_out)
		else $error("bus activity did not end sleep");
	a_sleep_late: assert property (
		$rose(sleep_out) |-> quiet_q >= QUIET)
		else $error("sleep entered before idle timeout");
endmodule
bind window_lift_motor_control window_lift_motor_control_assertions #(
	.BIT_CYC(BIT_CYC),
	.IDLE_BITS(IDLE_BITS)
) u_window_lift_motor_control_assertions (.*);
`default_nettype wire

// ===== dv/window_lift_motor_control_bench.sv
`timescale 1ns/100ps
`default_nettype none
module window_lift_motor_control_bench;
	import window_lift_pkg::*;
	localparam int BIT = 20;
	localparam int IDLE = 20;
	logic clock_in = 1'b0, arst_n_in = 1'b0, lin_rx_in;
	logic position_sensor_a_in = 1'b0, position_sensor_b_in = 1'b0;
	logic cmd_open_in = 1'b0, cmd_close_in = 1'b0, cmd_goto_in = 1'b0, cmd_stop_in = 1'b0;
	logic soft_ramp_in = 1'b0, constant_speed_in = 1'b0;
	logic left_node_select_in = 1'b1, right_node_select_in = 1'b0;
	logic enhanced_checksum_select_in = 1'b0, short_delimiter_fix_in = 1'b1;
	logic [15:0] target_position_in = 16'h0000, open_limit_in = 16'h1000;
	logic [15:0] period_difference_threshold_in = 16'h0002, end_zone_width_in = 16'h0000;
	logic [15:0] ramp_lead_counts_in = 16'h0000, obstruction_arm_delay_in = 16'h0000;
	logic [15:0] obstruction_arm_counts_in = 16'h0004, duty_update_ticks_in = 16'h0004;
	logic [15:0] target_period_in = 16'h0010, sensor_timeout_ticks_in = 16'h0008;
	logic [7:0]  obstruction_cycle_count_limit_in = 8'h03, ramp_increment_in = 8'h40;
	logic [7:0]  speed_regulation_increment_in = 8'h08, duty_min_stop_in = 8'h40;
	logic [7:0]  duty_min_pos_in = 8'h40, duty_max_in = 8'hC0;
	logic        pwm_out, motor_on_out, motor_open_dir_out, obstruction_out, end_stop_out;
	logic        sensor_missing_out, sleep_out, node_config_error_out, frame_valid_out;
	logic [15:0] position_out, sensor_period_out, frame_data_out, got_data, seen, c;
	logic [14:0] position_mm_out;
	logic [5:0]  frame_id_out, got_id, id;
	logic [4:0]  k;
	logic [4:0]  tbl [4] = '{5'b10001, 5'b01111, 5'b01100, 5'b11000};
	int          mismatches = 0, checks = 0, cycles = 0;
	window_lift_motor_control #(.BIT_CYC(BIT), .TICK_CYC(1000), .IDLE_BITS(IDLE))
		u_window_lift_motor_control (.*);
	lin_master_model #(.BIT_CYC(BIT)) u_lin_master_model (.clock_in(clock_in), .lin_out(lin_rx_in));
	always #5 clock_in = ~clock_in;
	// accepted frames, and the hang guard
	always @(posedge clock_in) begin
		cycles <= cycles + 1;
		if (frame_valid_out === 1'b1) begin
			seen <= seen + 16'h0001;
			got_id <= frame_id_out;
			got_data <= frame_data_out;
		end
		if (cycles == 100000) begin
			mismatches = mismatches + 1;
			test_done();
		end
	end
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		checks = checks + 1;
		if (got !== exp) begin
			mismatches = mismatches + 1;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tend(input string s);
		$display("test %s done", s);
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// one-cycle command pulse launched off the falling edge
	task automatic pulse(ref logic s);
		@(negedge clock_in);
		s = 1'b1;
		@(negedge clock_in);
		s = 1'b0;
	endtask
	// sensor-a edges with sensor-b giving the direction, gaps growing by grow
	task automatic edges(input int n, input logic open, input int gap, input int grow);
		for (int i = 0; i < n; i++) begin
			repeat (gap + grow * i) @(negedge clock_in);
			position_sensor_a_in = ~position_sensor_a_in;
			position_sensor_b_in = position_sensor_a_in ^ open;
		end
		repeat (10) @(negedge clock_in);
	endtask
	// high cycles of the drive output over 256 clocks
	task automatic duty();
		c = 16'h0000;
		repeat (256) begin
			@(negedge clock_in);
			c = c + {15'h0000, pwm_out};
		end
	endtask
	initial begin
		seen = 16'h0000;
		repeat (8) @(negedge clock_in);
		arst_n_in = 1'b1;
		check(position_out, POS_RESET);
		check({motor_on_out, obstruction_out, sensor_missing_out, sleep_out}, 16'h0000);
		tend("reset");
		pulse(cmd_open_in);
		repeat (2) @(negedge clock_in);
		check(motor_on_out, 1'b1);
		edges(6, 1'b1, 1500, 0);
		check(position_out, 16'h0006);
		check(position_mm_out, 15'h0003);
		check(motor_open_dir_out, 1'b1);
		tend("open");
		pulse(cmd_close_in);
		edges(4, 1'b0, 1500, 0);
		check(position_out, 16'h0002);
		check(motor_open_dir_out, 1'b0);
		pulse(cmd_stop_in);
		repeat (3) @(negedge clock_in);
		check(motor_on_out, 1'b0);
		tend("close");
		soft_ramp_in = 1'b1;
		target_position_in = 16'h0005;
		ramp_lead_counts_in = 16'h0002;
		duty_min_pos_in = 8'h30;
		pulse(cmd_goto_in);
		edges(3, 1'b1, 1500, 0);
		check(position_out, 16'h0005);
		check(motor_on_out, 1'b0);
		tend("goto");
		pulse(cmd_open_in);
		repeat (10000) @(negedge clock_in);
		check(sensor_missing_out, 1'b1);
		check(motor_on_out, 1'b0);
		tend("sensor loss");
		pulse(cmd_open_in);
		repeat (4) @(negedge clock_in);
		check(sensor_missing_out, 1'b0);
		duty();
		check(c >= 16'h0040 && c < 16'h0100, 1'b1);
		edges(3, 1'b1, 1200, 0);
		duty();
		check(c, 16'h0100);
		pulse(cmd_stop_in);
		edges(4, 1'b1, 1500, 0);
		check(motor_on_out, 1'b0);
		tend("soft ramps");
		soft_ramp_in = 1'b0;
		pulse(cmd_open_in);
		edges(10, 1'b1, 300, 300);
		check(obstruction_out, 1'b1);
		check(motor_on_out, 1'b0);
		check(end_stop_out, 1'b0);
		check(sensor_period_out > 16'h001C && sensor_period_out < 16'h001F, 1'b1);
		tend("obstruction");
		// growing gaps again, inside the end zone: end stop instead of pinch
		end_zone_width_in = 16'hFFFF;
		pulse(cmd_open_in);
		edges(7, 1'b1, 100, 300);
		check({obstruction_out, end_stop_out, motor_on_out}, 16'h0002);
		end_zone_width_in = 16'h0000;
		tend("end zone");
		// short sensor periods make regulation lower the duty once per interval
		constant_speed_in = 1'b1;
		pulse(cmd_open_in);
		edges(12, 1'b1, 500, 0);
		duty();
		check(c, 16'h00F7);
		pulse(cmd_stop_in);
		constant_speed_in = 1'b0;
		tend("constant speed");
		for (int i = 0; i < 4; i++) begin
			k = tbl[i];
			{left_node_select_in, right_node_select_in, enhanced_checksum_select_in} = k[4:2];
			id = (k[3] && !k[4]) ? RIGHT_FRAME_ID : LEFT_FRAME_ID;
			seen = 16'h0000;
			u_lin_master_model.send(id, 16'h3CA5 ^ 16'(i), k[1]);
			repeat (20) @(negedge clock_in);
			check(seen, {15'h0000, k[0]});
			check(node_config_error_out, k[4] & k[3]);
			if (k[0]) begin
				check(got_id, id);
				check(got_data, 16'h3CA5 ^ 16'(i));
			end
		end
		tend("frames");
		repeat (IDLE * BIT + 50) @(negedge clock_in);
		check(sleep_out, 1'b1);
		{left_node_select_in, right_node_select_in, enhanced_checksum_select_in} = 3'b100;
		short_delimiter_fix_in = 1'b0;
		seen = 16'h0000;
		u_lin_master_model.send(LEFT_FRAME_ID, 16'h0001, 1'b0);
		repeat (20) @(negedge clock_in);
		check(sleep_out, 1'b0);
		check(seen, 16'h0001);
		tend("sleep");
		test_done();
	end
endmodule
`default_nettype wire

// ===== verilog/window_lift_motor_control.sv
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// RULE_01: one full sensor-a period equals one millimetre of glass travel.
// RULE_02: serial link bit rate is fixed at 9.6 kBd.
// RULE_03: count a cycle when consecutive sensor-a periods differ beyond the threshold.
// RULE_04: declare pinch or stall and stop after enough counted cycles.
// RULE_05: an end zone near both ends turns stall into end-stop handling.
// RULE_06: position counts half-periods, up or down per sensor-a edge.
// RULE_07: soft stop ramps duty down to no lower than the stop minimum.
// RULE_08: move-to-target ramps down to the positioning minimum near the target.
// RULE_09: soft start ramps to the maximum, then forces full duty.
// RULE_10: ramps change duty by the ramp increment.
// RULE_11: constant-speed mode steps duty by the speed regulation increment.
// RULE_12: constant-speed updates occur every chosen number of periodic ticks.
// RULE_13: stopping ramps begin the lead count before the stopping point.
// RULE_14: constant-speed mode holds the sensor-a period at the target period.
// RULE_15: flag missing sensor after a number of ticks without sensor edges.
// RULE_16: obstruction detection armed only after a number of ticks from start.
// RULE_17: obstruction detection evaluated only after a number of position counts.
// RULE_18: node is left or right, never both.
// RULE_19: enhanced checksum adds the identifier to the data bytes.
// RULE_20: a one-bit break delimiter is accepted even with a slow local clock.
// RULE_21: capture sensor-a on both edges, sample sensor-b for direction.
// RULE_22: sleep after 25000 idle bit times; any bus activity reloads the count.
// RULE_23: one ramp step per periodic tick during soft ramps.
module window_lift_motor_control #(
	parameter int BIT_CYC  = window_lift_pkg::BIT_CYCLES,
	parameter int TICK_CYC = window_lift_pkg::TICK_CYCLES,
	parameter int IDLE_BITS = window_lift_pkg::IDLE_TIMEOUT_BITS
) (
	input  wire logic        clock_in,
	input  wire logic        arst_n_in,
	input  wire logic        position_sensor_a_in,
	input  wire logic        position_sensor_b_in,
	input  wire logic        lin_rx_in,
	input  wire logic        cmd_open_in,
	input  wire logic        cmd_close_in,
	input  wire logic        cmd_goto_in,
	input  wire logic        cmd_stop_in,
	input  wire logic [15:0] target_position_in,
	input  wire logic [15:0] open_limit_in,
	input  wire logic        soft_ramp_in,
	input  wire logic        constant_speed_in,
	input  wire logic [15:0] period_difference_threshold_in,
	input  wire logic [7:0]  obstruction_cycle_count_limit_in,
	input  wire logic [15:0] end_zone_width_in,
	input  wire logic [7:0]  ramp_increment_in,
	input  wire logic [7:0]  speed_regulation_increment_in,
	input  wire logic [15:0] ramp_lead_counts_in,
	input  wire logic [15:0] obstruction_arm_delay_in,
	input  wire logic [15:0] obstruction_arm_counts_in,
	input  wire logic [7:0]  duty_min_stop_in,
	input  wire logic [7:0]  duty_min_pos_in,
	input  wire logic [7:0]  duty_max_in,
	input  wire logic [15:0] duty_update_ticks_in,
	input  wire logic [15:0] target_period_in,
	input  wire logic [15:0] sensor_timeout_ticks_in,
	input  wire logic        left_node_select_in,
	input  wire logic        right_node_select_in,
	input  wire logic        enhanced_checksum_select_in,
	input  wire logic        short_delimiter_fix_in,
	output logic             pwm_out,
	output logic             motor_on_out,
	output logic             motor_open_dir_out,
	output logic [15:0]      position_out,
	output logic [14:0]      position_mm_out,
	output logic [15:0]      sensor_period_out,
	output logic             obstruction_out,
	output logic             end_stop_out,
	output logic             sensor_missing_out,
	output logic             sleep_out,
	output logic             node_config_error_out,
	output logic             frame_valid_out,
	output logic [5:0]       frame_id_out,
	output logic [15:0]      frame_data_out
);
	import window_lift_pkg::*;

	function automatic logic [15:0] abs_diff(input logic [15:0] a, input logic [15:0] b);
		abs_diff = (a > b) ? a - b : b - a;
	endfunction

	function automatic logic [7:0] sat_add(input logic [7:0] a, input logic [7:0] b);
		logic [8:0] s;
		s = {1'b0, a} + {1'b0, b};
		sat_add = s[8] ? DUTY_FULL : s[7:0];
	endfunction

	function automatic logic [7:0] sat_sub(input logic [7:0] a, input logic [7:0] b);
		sat_sub = (a > b) ? a - b : DUTY_RESET;
	endfunction

	// three-stage synchronisers; a level counts once stages two and three agree
	logic [2:0] a_s_q, b_s_q, rx_s_q;
	logic       a_q, b_q, rx_q;
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			a_s_q  <= 3'h0;
			b_s_q  <= 3'h0;
			rx_s_q <= 3'h7;
			a_q    <= 1'b0;
			b_q    <= 1'b0;
			rx_q   <= 1'b1;
		end else begin
			a_s_q  <= {a_s_q[1:0], position_sensor_a_in};
			b_s_q  <= {b_s_q[1:0], position_sensor_b_in};
			rx_s_q <= {rx_s_q[1:0], lin_rx_in};
			if (a_s_q[1] == a_s_q[2]) a_q <= a_s_q[2];
			if (b_s_q[1] == b_s_q[2]) b_q <= b_s_q[2];
			if (rx_s_q[1] == rx_s_q[2]) rx_q <= rx_s_q[2];
		end
	end

	logic a_d1_q, rx_d1_q;
	wire  cap_edge = a_q ^ a_d1_q; // both edges of sensor a
	wire  rx_edge  = rx_q ^ rx_d1_q;

	// periodic tick and capture timebases
	logic [31:0] tick_div_q;
	logic [7:0]  cap_div_q;
	logic [15:0] cap_cnt_q, period_q, prev_period_q;
	logic        tick_q;
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			tick_div_q <= 32'h0;
			tick_q     <= 1'b0;
			cap_div_q  <= 8'h0;
			cap_cnt_q  <= 16'h0;
			period_q   <= 16'h0;
			prev_period_q <= 16'h0;
			a_d1_q     <= 1'b0;
			rx_d1_q    <= 1'b1;
		end else begin
			a_d1_q  <= a_q;
			rx_d1_q <= rx_q;
			tick_q  <= (tick_div_q == 32'(TICK_CYC - 1));
			tick_div_q <= (tick_div_q == 32'(TICK_CYC - 1)) ? 32'h0 : tick_div_q + 32'h1;
			cap_div_q  <= (cap_div_q == 8'(CAPTURE_DIV - 1)) ? 8'h0 : cap_div_q + 8'h1;
			if (cap_edge) begin
				period_q      <= cap_cnt_q;
				prev_period_q <= period_q;
				cap_cnt_q     <= 16'h0;
			end else if (cap_div_q == 8'(CAPTURE_DIV - 1) && cap_cnt_q != 16'hFFFF) begin
				cap_cnt_q <= cap_cnt_q + 16'h1;
			end
		end
	end

	// position in half-periods, direction from sensor b at each capture
	logic [15:0] pos_q;
	logic        dir_open_q;
	wire         edge_open = a_q ^ b_q; // RULE_21
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			pos_q      <= POS_RESET;
			dir_open_q <= 1'b0;
		end else if (cap_edge) begin
			dir_open_q <= edge_open; // RULE_21
			pos_q <= edge_open ? pos_q + 16'h1 : pos_q - 16'h1; // RULE_06
		end
	end

	motor_state_t state_q;
	logic [7:0]   duty_q, floor_q;
	logic         goto_q, open_q, moving;
	logic [15:0]  run_ticks_q, run_counts_q, idle_sensor_q, upd_q;
	logic [7:0]   obst_cnt_q;
	logic [15:0]  stop_point;
	assign moving = (state_q != M_IDLE);
	assign stop_point = goto_q ? target_position_in : (open_q ? open_limit_in : POS_RESET);
	wire in_end_zone = (pos_q <= end_zone_width_in) ||
	                   (pos_q >= open_limit_in - end_zone_width_in); // RULE_05
	wire armed = (run_ticks_q >= obstruction_arm_delay_in) && // RULE_16
	             (run_counts_q >= obstruction_arm_counts_in); // RULE_17
	wire obst_cycle = cap_edge && armed && moving &&
	                  (abs_diff(period_q, prev_period_q) > period_difference_threshold_in); // RULE_03
	wire obst_hit = obst_cycle && (obst_cnt_q + 8'h1 >= obstruction_cycle_count_limit_in); // RULE_04
	wire sensor_lost = moving && tick_q && (idle_sensor_q + 16'h1 >= sensor_timeout_ticks_in); // RULE_15
	wire at_goal = goto_q ? (pos_q == target_position_in) :
	               (open_q ? (pos_q >= open_limit_in) : (pos_q == POS_RESET));
	wire halt = obst_hit || sensor_lost || at_goal || (cmd_stop_in && !soft_ramp_in);
	wire start = cmd_open_in || cmd_close_in || cmd_goto_in;

	// counters since start and obstruction cycle count
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			run_ticks_q   <= 16'h0;
			run_counts_q  <= 16'h0;
			idle_sensor_q <= 16'h0;
			obst_cnt_q    <= 8'h0;
		end else if (start) begin
			run_ticks_q   <= 16'h0;
			run_counts_q  <= 16'h0;
			idle_sensor_q <= 16'h0;
			obst_cnt_q    <= 8'h0;
		end else begin
			if (tick_q && run_ticks_q != 16'hFFFF) run_ticks_q <= run_ticks_q + 16'h1;
			if (cap_edge && run_counts_q != 16'hFFFF) run_counts_q <= run_counts_q + 16'h1;
			if (cap_edge) idle_sensor_q <= 16'h0;
			else if (tick_q && idle_sensor_q != 16'hFFFF) idle_sensor_q <= idle_sensor_q + 16'h1;
			if (obst_cycle && obst_cnt_q != 8'hFF) obst_cnt_q <= obst_cnt_q + 8'h1; // RULE_03
		end
	end

	// status flags; a new event wins over the clear at a new command
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			obstruction_out    <= 1'b0;
			end_stop_out       <= 1'b0;
			sensor_missing_out <= 1'b0;
		end else begin
			if (obst_hit && !in_end_zone) obstruction_out <= 1'b1; // RULE_04
			else if (start) obstruction_out <= 1'b0;
			if (obst_hit && in_end_zone) end_stop_out <= 1'b1; // RULE_05
			else if (start) end_stop_out <= 1'b0;
			if (sensor_lost) sensor_missing_out <= 1'b1; // RULE_15
			else if (start) sensor_missing_out <= 1'b0;
		end
	end

	// motor sequencing and duty ramps
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_q <= M_IDLE;
			duty_q  <= DUTY_RESET;
			floor_q <= DUTY_RESET;
			goto_q  <= 1'b0;
			open_q  <= 1'b0;
			upd_q   <= 16'h0;
		end else if (start) begin
			goto_q  <= cmd_goto_in;
			open_q  <= cmd_open_in || (cmd_goto_in && target_position_in > pos_q);
			upd_q   <= 16'h0;
			state_q <= soft_ramp_in ? M_START : M_RUN;
			duty_q  <= soft_ramp_in ? duty_min_stop_in : DUTY_FULL;
		end else if (moving && halt) begin
			state_q <= M_IDLE;
			duty_q  <= DUTY_RESET;
		end else begin
			case (state_q)
				M_START: begin
					if (tick_q) begin // RULE_23
						if (sat_add(duty_q, ramp_increment_in) >= duty_max_in) begin
							duty_q  <= DUTY_FULL; // RULE_09
							state_q <= M_RUN;
						end else begin
							duty_q <= sat_add(duty_q, ramp_increment_in); // RULE_10
						end
					end
				end
				M_RUN: begin
					if (cmd_stop_in) begin
						floor_q <= duty_min_stop_in; // RULE_07
						state_q <= M_STOP;
					end else if (soft_ramp_in &&
					             abs_diff(pos_q, stop_point) <= ramp_lead_counts_in) begin
						floor_q <= goto_q ? duty_min_pos_in : duty_min_stop_in; // RULE_08
						state_q <= M_STOP; // RULE_13
					end else if (constant_speed_in && tick_q) begin
						if (upd_q + 16'h1 >= duty_update_ticks_in) begin // RULE_12
							upd_q <= 16'h0;
							if (period_q > target_period_in) // RULE_14
								duty_q <= sat_add(duty_q, speed_regulation_increment_in); // RULE_11
							else if (period_q < target_period_in)
								duty_q <= sat_sub(duty_q, speed_regulation_increment_in);
						end else begin
							upd_q <= upd_q + 16'h1;
						end
					end
				end
				M_STOP: begin
					if (tick_q) begin // RULE_23
						if (sat_sub(duty_q, ramp_increment_in) <= floor_q) begin
							duty_q <= floor_q; // RULE_07
							if (!goto_q && floor_q == duty_min_stop_in && cmd_stop_in == 1'b0
							    && abs_diff(pos_q, stop_point) > ramp_lead_counts_in) begin
								state_q <= M_IDLE; // soft stop by command ends at the floor
								duty_q  <= DUTY_RESET;
							end
						end else begin
							duty_q <= sat_sub(duty_q, ramp_increment_in); // RULE_10
						end
					end
				end
				default: state_q <= M_IDLE;
			endcase
		end
	end

	// pwm generator and registered motor outputs
	logic [7:0] pwm_cnt_q;
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			pwm_cnt_q          <= 8'h0;
			pwm_out            <= 1'b0;
			motor_on_out       <= 1'b0;
			motor_open_dir_out <= 1'b0;
			position_out       <= POS_RESET;
			position_mm_out    <= 15'h0;
			sensor_period_out  <= 16'h0;
		end else begin
			pwm_cnt_q          <= pwm_cnt_q + 8'h1;
			pwm_out            <= moving && (duty_q == DUTY_FULL || pwm_cnt_q < duty_q);
			motor_on_out       <= moving;
			motor_open_dir_out <= open_q;
			position_out       <= pos_q;
			position_mm_out    <= 15'(pos_q / 16'(HALF_PERIODS_PER_MM)); // RULE_01
			sensor_period_out  <= period_q;
		end
	end

	// serial receiver: break, delimiter, bytes, checksum
	rx_state_t   rx_state_q;
	logic [31:0] rx_cnt_q, idle_cyc_q;
	logic [15:0] idle_bits_q;
	logic [3:0]  bit_idx_q, byte_idx_q;
	logic [7:0]  shift_q, id_q;
	logic [8:0]  sum_q;
	logic [15:0] data_q;
	wire  [8:0]  sum_next = {1'b0, sum_q[7:0]} + {8'h0, sum_q[8]} + {1'b0, shift_q};
	wire  [31:0] delim_min = short_delimiter_fix_in ? 32'(BIT_CYC / 2) : 32'(BIT_CYC); // RULE_20
	wire  [5:0]  my_id = left_node_select_in ? LEFT_FRAME_ID : RIGHT_FRAME_ID;
	wire         last_byte = (byte_idx_q == 4'(FRAME_DATA_BYTES + 2));
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rx_state_q <= R_HUNT;
			rx_cnt_q   <= 32'h0;
			bit_idx_q  <= 4'h0;
			byte_idx_q <= 4'h0;
			shift_q    <= 8'h0;
			id_q       <= 8'h0;
			sum_q      <= 9'h0;
			data_q     <= 16'h0;
			frame_valid_out <= 1'b0;
			frame_id_out    <= 6'h0;
			frame_data_out  <= 16'h0;
		end else begin
			frame_valid_out <= 1'b0;
			case (rx_state_q)
				R_HUNT: begin
					rx_cnt_q <= rx_q ? 32'h0 : rx_cnt_q + 32'h1;
					if (rx_q && rx_cnt_q >= 32'(BREAK_BITS * BIT_CYC)) begin
						rx_state_q <= R_DELIM;
						rx_cnt_q   <= 32'h0;
					end
				end
				R_DELIM: begin
					rx_cnt_q <= rx_cnt_q + 32'h1;
					if (!rx_q) begin
						// the count lags the high cycles seen by one, so add it back
						rx_state_q <= (rx_cnt_q + 32'h1 >= delim_min) ? R_BITS : R_HUNT; // RULE_20
						rx_cnt_q   <= 32'h0;
						bit_idx_q  <= 4'h0;
						byte_idx_q <= 4'h0;
						sum_q      <= 9'h0;
					end
				end
				R_WAIT: begin
					if (!rx_q) begin
						rx_state_q <= R_BITS;
						rx_cnt_q   <= 32'h0;
						bit_idx_q  <= 4'h0;
					end
				end
				R_BITS: begin
					rx_cnt_q <= rx_cnt_q + 32'h1;
					if (rx_cnt_q == 32'(BIT_CYC / 2 + BIT_CYC * 32'(bit_idx_q))) begin // RULE_02
						bit_idx_q <= bit_idx_q + 4'h1;
						if (bit_idx_q == 4'h0 && rx_q) rx_state_q <= R_HUNT;
						else if (bit_idx_q >= 4'h1 && bit_idx_q <= 4'h8) shift_q <= {rx_q, shift_q[7:1]};
						else if (bit_idx_q == 4'h9) begin
							rx_state_q <= R_WAIT;
							byte_idx_q <= byte_idx_q + 4'h1;
							if (!rx_q || (byte_idx_q == 4'h0 && shift_q != SYNC_BYTE)) rx_state_q <= R_HUNT;
							if (byte_idx_q == 4'h1) begin
								id_q <= shift_q;
								if (enhanced_checksum_select_in) sum_q <= {1'b0, shift_q}; // RULE_19
							end else if (byte_idx_q >= 4'h2 && !last_byte) begin
								sum_q  <= sum_next; // RULE_19
								data_q <= {shift_q, data_q[15:8]};
							end
							if (last_byte) begin
								rx_state_q <= R_HUNT;
								frame_valid_out <= (shift_q == ~(sum_q[7:0] + {7'h0, sum_q[8]})) &&
								    (id_q[5:0] == my_id) && (left_node_select_in ^ right_node_select_in); // RULE_18
								frame_id_out   <= id_q[5:0];
								frame_data_out <= data_q;
							end
						end
					end
				end
				default: rx_state_q <= R_HUNT;
			endcase
		end
	end

	// bus idle timeout and node configuration check
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			idle_cyc_q  <= 32'h0;
			idle_bits_q <= 16'h0;
			sleep_out   <= 1'b0;
			node_config_error_out <= 1'b0;
		end else begin
			node_config_error_out <= !(left_node_select_in ^ right_node_select_in); // RULE_18
			if (rx_edge) begin
				idle_cyc_q  <= 32'h0; // RULE_22
				idle_bits_q <= 16'h0;
				sleep_out   <= 1'b0;
			end else if (idle_cyc_q == 32'(BIT_CYC - 1)) begin
				idle_cyc_q <= 32'h0;
				if (idle_bits_q != 16'hFFFF) idle_bits_q <= idle_bits_q + 16'h1;
				if (idle_bits_q + 16'h1 >= 16'(IDLE_BITS)) sleep_out <= 1'b1; // RULE_22
			end else begin
				idle_cyc_q <= idle_cyc_q + 32'h1;
			end
		end
	end
endmodule
`default_nettype wire

// ===== verilog/window_lift_pkg.sv
package window_lift_pkg;
	localparam int          CLK_HZ           = 100_000_000;
	localparam int          BAUD_RATE        = 9_600;
	localparam int          BIT_CYCLES       = CLK_HZ / BAUD_RATE;
	localparam int          TICK_PERIOD_US   = 1_000;
	localparam int          TICK_CYCLES      = TICK_PERIOD_US * (CLK_HZ / 1_000_000);
	localparam int          CAPTURE_DIV      = 100;
	localparam int          IDLE_TIMEOUT_BITS = 25_000;
	localparam int          BREAK_BITS       = 11;
	localparam int          HALF_PERIODS_PER_MM = 2;
	localparam int          FRAME_DATA_BYTES = 2;
	localparam logic [7:0]  SYNC_BYTE        = 8'h55;
	localparam logic [7:0]  DUTY_FULL        = 8'hFF;
	localparam logic [7:0]  DUTY_RESET       = 8'h00;
	localparam logic [15:0] POS_RESET        = 16'h0000;
	localparam logic [5:0]  LEFT_FRAME_ID    = 6'h11;
	localparam logic [5:0]  RIGHT_FRAME_ID   = 6'h12;
	typedef enum logic [3:0] {
		M_IDLE  = 4'b0001,
		M_START = 4'b0010,
		M_RUN   = 4'b0100,
		M_STOP  = 4'b1000
	} motor_state_t;
	typedef enum logic [3:0] {
		R_HUNT  = 4'b0001,
		R_DELIM = 4'b0010,
		R_WAIT  = 4'b0100,
		R_BITS  = 4'b1000
	} rx_state_t;
endpackage
